// file: trs_sequencer.v
// Trap entry, status-restoring return, coroutine switch and marked jump sequencer.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "trs_regs.vh"
module trs_sequencer (
  input wire clock,
  input wire rst,
  // AXI4-Lite register slave.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Command port from the decode stage.
  input wire cmdValid,
  output wire cmdReady,
  input wire [2:0] cmdOp,
  input wire [5:0] cmdModifier,
  input wire [31:0] firstOperand,
  input wire [31:0] secondOperand,
  input wire [31:0] firstValue,
  input wire [31:0] followingInstrAddr,
  input wire userMode,
  input wire callTraceEnable,
  // Stack and data memory port.
  output reg memReq,
  output reg memWe,
  output reg [31:0] memAddr,
  output reg [31:0] memWdata,
  input wire memAck,
  input wire [31:0] memRdata,
  // Architectural state and results.
  output reg cmdDone,
  output reg pcLoad,
  output reg [31:0] pcValue,
  output reg [31:0] stackTopPointer,
  output reg [31:0] userStatus,
  output reg [31:0] procStatus,
  output reg [31:0] elementState,
  output reg singleStepPending,
  output reg callWatchPending,
  output reg execSpace,
  output reg firstResultValid,
  output reg [31:0] firstResult,
  output reg segmentCrossFault,
  output reg illegalOpFault,
  output reg callEvent,
  output reg returnEvent,
  output wire irq
);
  // ==================================================================
  // Sequencer states.
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_RET_RD = 4'h1;
  localparam [3:0] ST_RET_APPLY = 4'h2;
  localparam [3:0] ST_VEC_HND = 4'h3;
  localparam [3:0] ST_VEC_DESC = 4'h4;
  localparam [3:0] ST_OPND_RD = 4'h5;
  localparam [3:0] ST_PUSH = 4'h6;
  localparam [3:0] ST_CO_RD0 = 4'h7;
  localparam [3:0] ST_CO_WR0 = 4'h8;
  localparam [3:0] ST_CO_RD1 = 4'h9;
  localparam [3:0] ST_CO_WR1 = 4'hA;

  reg [3:0] state; // Current sequencer state.
  reg [2:0] op; // Operation latched at acceptance.
  reg advance; // Advance form of a return.
  reg [2:0] saveIdx; // Save area word being read.
  reg [31:0] saveBase; // First word of the save area.
  reg [31:0] savedPc, savedNext, savedUsr, savedPsw, savedState;
  reg [31:0] handler; // Trap handler address.
  reg [3:0] desc; // Operand evaluation modes.
  reg opndSel; // Zero for the first trap operand.
  reg [31:0] opA, opB, retAddr; // Latched operands and coroutine return address.
  reg ctrlEnable; // Software enable for new commands.
  reg [31:0] vecBase; // Executive trap vector table base.

  // ==================================================================
  // AXI4-Lite slave. Address and data are taken in either order.
  reg awHeld, wHeld;
  reg [7:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire [`TRS_IRQ_W-1:0] irqStatus, irqMask;
  reg [`TRS_IRQ_W-1:0] irqEvents;
  wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
  wire fullWord = &wStrb;
  // Sub-word writes are ignored; every register is a full word.
  wire wrCtrl = doWrite & fullWord & (awAddr == `TRS_OFF_CTRL);
  wire wrVec = doWrite & fullWord & (awAddr == `TRS_OFF_VECBASE);
  wire wrClr = doWrite & fullWord & (awAddr == `TRS_OFF_IRQ_STATUS);
  wire wrMask = doWrite & fullWord & (awAddr == `TRS_OFF_IRQ_MASK);
  wire wrKnown = (awAddr == `TRS_OFF_CTRL) | (awAddr == `TRS_OFF_VECBASE) |
                 (awAddr == `TRS_OFF_IRQ_STATUS) | (awAddr == `TRS_OFF_IRQ_MASK) |
                 (awAddr == `TRS_OFF_PC) | (awAddr == `TRS_OFF_SP) |
                 (awAddr == `TRS_OFF_STATE);

  assign s_axi_awready = ~awHeld;
  assign s_axi_wready = ~wHeld;
  assign s_axi_arready = ~s_axi_rvalid;

  // Write channel capture and response.
  always @(posedge clock) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= `TRS_ZERO32;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TRS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? `TRS_RESP_OKAY : `TRS_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        // Release both holders only once the response is taken.
        s_axi_bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
      end
    end
  end

  // Writable control registers.
  always @(posedge clock) begin
    if (rst) begin
      ctrlEnable <= `TRS_CTRL_RESET;
      vecBase <= `TRS_VECBASE_RESET;
    end else begin
      if (wrCtrl) begin
        ctrlEnable <= wData[0];
      end
      if (wrVec) begin
        vecBase <= wData;
      end
    end
  end

  // Read channel: one cycle to the answer; unknown offsets give SLVERR.
  always @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `TRS_ZERO32;
      s_axi_rresp <= `TRS_RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TRS_RESP_OKAY;
      case (s_axi_araddr)
        `TRS_OFF_CTRL: s_axi_rdata <= {31'h0000_0000, ctrlEnable};
        `TRS_OFF_VECBASE: s_axi_rdata <= vecBase;
        `TRS_OFF_IRQ_STATUS: s_axi_rdata <= {27'h000_0000, irqStatus};
        `TRS_OFF_IRQ_MASK: s_axi_rdata <= {27'h000_0000, irqMask};
        `TRS_OFF_PC: s_axi_rdata <= pcValue;
        `TRS_OFF_SP: s_axi_rdata <= stackTopPointer;
        `TRS_OFF_STATE: s_axi_rdata <= {24'h00_0000, execSpace, callWatchPending,
                                        singleStepPending, 1'b0, state};
        default: begin
          s_axi_rdata <= `TRS_ZERO32;
          s_axi_rresp <= `TRS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==================================================================
  // Event flags and interrupt output.
  always @* begin
    irqEvents = {`TRS_IRQ_W{1'b0}};
    irqEvents[`TRS_IRQ_SEG] = segmentCrossFault;
    irqEvents[`TRS_IRQ_ILLEGAL] = illegalOpFault;
    irqEvents[`TRS_IRQ_TRAP] = pcLoad & execSpace & (op == `TRS_OP_EXEC_TRAP);
    irqEvents[`TRS_IRQ_CALL] = callEvent;
    irqEvents[`TRS_IRQ_RET] = returnEvent;
  end

  trs_irq_bank #(.W(`TRS_IRQ_W)) irqBank (
    .clock(clock),
    .rst(rst),
    .events(irqEvents),
    .clearWrite(wrClr),
    .clearBits(wData[`TRS_IRQ_W-1:0]),
    .maskWrite(wrMask),
    .maskBits(wData[`TRS_IRQ_W-1:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irq)
  );

  // ==================================================================
  // Sequencer.
  assign cmdReady = (state == ST_IDLE) & ctrlEnable;
  wire accept = cmdValid & cmdReady;
  wire isReturn = (cmdOp == `TRS_OP_USER_RET) | (cmdOp == `TRS_OP_FULL_RET);
  // Stack pointer would leave its segment.
  wire segCross = secondOperand[31:`TRS_SEG_LSB] != stackTopPointer[31:`TRS_SEG_LSB];
  wire [1:0] curMode = opndSel ? desc[`TRS_MODE2_LSB+1:`TRS_MODE2_LSB] :
                                 desc[`TRS_MODE1_LSB+1:`TRS_MODE1_LSB];
  wire [31:0] curOpnd = opndSel ? opB : opA;
  wire stateNonZero = savedState != `TRS_ZERO32;

  // Main process. The register file is never written by returns.
  always @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      op <= `TRS_OP_PLAIN_JUMP;
      advance <= 1'b0;
      saveIdx <= 3'h0;
      saveBase <= `TRS_ZERO32;
      savedPc <= `TRS_ZERO32;
      savedNext <= `TRS_ZERO32;
      savedUsr <= `TRS_ZERO32;
      savedPsw <= `TRS_ZERO32;
      savedState <= `TRS_ZERO32;
      handler <= `TRS_ZERO32;
      desc <= 4'h0;
      opndSel <= 1'b0;
      opA <= `TRS_ZERO32;
      opB <= `TRS_ZERO32;
      retAddr <= `TRS_ZERO32;
      memReq <= 1'b0;
      memWe <= 1'b0;
      memAddr <= `TRS_ZERO32;
      memWdata <= `TRS_ZERO32;
      cmdDone <= 1'b0;
      pcLoad <= 1'b0;
      pcValue <= `TRS_PC_RESET;
      stackTopPointer <= `TRS_SP_RESET;
      userStatus <= `TRS_ZERO32;
      procStatus <= `TRS_ZERO32;
      elementState <= `TRS_ZERO32;
      singleStepPending <= 1'b0;
      callWatchPending <= 1'b0;
      execSpace <= 1'b0;
      firstResultValid <= 1'b0;
      firstResult <= `TRS_ZERO32;
      segmentCrossFault <= 1'b0;
      illegalOpFault <= 1'b0;
      callEvent <= 1'b0;
      returnEvent <= 1'b0;
    end else begin
      // Pulses default low.
      cmdDone <= 1'b0;
      pcLoad <= 1'b0;
      firstResultValid <= 1'b0;
      segmentCrossFault <= 1'b0;
      illegalOpFault <= 1'b0;
      callEvent <= 1'b0;
      returnEvent <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            op <= cmdOp;
            advance <= cmdModifier[0];
            opA <= firstOperand;
            opB <= secondOperand;
            if ((cmdOp == `TRS_OP_FULL_RET) & userMode) begin
              illegalOpFault <= 1'b1;
              cmdDone <= 1'b1;
            end else if (isReturn & segCross) begin
              // Fault before anything changes.
              segmentCrossFault <= 1'b1;
              cmdDone <= 1'b1;
            end else if (isReturn) begin
              // Pop the handler stack, then walk the save area.
              stackTopPointer <= secondOperand;
              saveBase <= firstOperand;
              saveIdx <= `TRS_SAVE_PC;
              memReq <= 1'b1;
              memWe <= 1'b0;
              memAddr <= firstOperand;
              state <= ST_RET_RD;
            end else if (cmdOp == `TRS_OP_EXEC_TRAP) begin
              // Vector entry is two words, picked by the 6-bit modifier.
              memReq <= 1'b1;
              memWe <= 1'b0;
              memAddr <= vecBase + ({26'h000_0000, cmdModifier} << `TRS_VEC_SHIFT);
              state <= ST_VEC_HND;
            end else if (cmdOp == `TRS_OP_CORO) begin
              // First read the word that is swapped with the first operand.
              memReq <= 1'b1;
              memWe <= 1'b0;
              memAddr <= secondOperand;
              state <= ST_CO_RD0;
            end else begin
              // Marked jumps are plain jumps plus a trace event.
              pcValue <= firstOperand;
              pcLoad <= 1'b1;
              cmdDone <= 1'b1;
              callEvent <= (cmdOp == `TRS_OP_CALL_JUMP) & callTraceEnable;
              returnEvent <= (cmdOp == `TRS_OP_RET_JUMP) & callTraceEnable;
            end
          end
        end
        ST_RET_RD: begin
          if (memAck) begin
            case (saveIdx)
              `TRS_SAVE_PC: savedPc <= memRdata;
              `TRS_SAVE_NEXT: savedNext <= memRdata;
              `TRS_SAVE_USR: savedUsr <= memRdata;
              `TRS_SAVE_PSW: savedPsw <= memRdata;
              default: savedState <= memRdata;
            endcase
            if (saveIdx == `TRS_SAVE_LAST) begin
              memReq <= 1'b0;
              state <= ST_RET_APPLY;
            end else begin
              saveIdx <= saveIdx + 3'h1;
              memAddr <= memAddr + `TRS_WORD;
            end
          end
        end
        ST_RET_APPLY: begin
          userStatus <= savedUsr;
          if (op == `TRS_OP_FULL_RET) begin
            procStatus <= savedPsw;
            execSpace <= 1'b0;
          end
          if (stateNonZero) begin
            // Stay on the vector instruction; advance moves one element on.
            pcValue <= savedPc;
            elementState <= advance ? savedState + 32'h0000_0001 : savedState;
            if (advance & (op == `TRS_OP_FULL_RET)) begin
              singleStepPending <= savedPsw[`TRS_PSW_TRACE_EN];
              callWatchPending <= savedPsw[`TRS_PSW_CALL_PEND];
            end
          end else begin
            pcValue <= advance ? savedNext : savedPc;
            elementState <= `TRS_ZERO32;
          end
          pcLoad <= 1'b1;
          cmdDone <= 1'b1;
          state <= ST_IDLE;
        end
        ST_VEC_HND: begin
          if (memAck) begin
            handler <= memRdata;
            memAddr <= memAddr + `TRS_WORD;
            state <= ST_VEC_DESC;
          end
        end
        ST_VEC_DESC: begin
          if (memAck) begin
            desc <= memRdata[3:0];
            opndSel <= 1'b0;
            memReq <= 1'b0;
            state <= ST_OPND_RD;
          end
        end
        ST_OPND_RD: begin
          // Evaluate one operand per pass: skip, address, or fetched contents.
          if (memReq) begin
            if (memAck) begin
              memWe <= 1'b1;
              memWdata <= memRdata;
              memAddr <= stackTopPointer;
              state <= ST_PUSH;
            end
          end else if (curMode == `TRS_MODE_NONE) begin
            if (opndSel) begin
              pcValue <= handler;
              execSpace <= 1'b1;
              pcLoad <= 1'b1;
              cmdDone <= 1'b1;
              state <= ST_IDLE;
            end
            opndSel <= 1'b1;
          end else if (curMode == `TRS_MODE_ADDR) begin
            memReq <= 1'b1;
            memWe <= 1'b1;
            memWdata <= curOpnd;
            memAddr <= stackTopPointer;
            state <= ST_PUSH;
          end else begin
            memReq <= 1'b1;
            memWe <= 1'b0;
            memAddr <= curOpnd;
          end
        end
        ST_PUSH: begin
          if (memAck) begin
            // Upward stack: pointer moves past the word just written.
            stackTopPointer <= stackTopPointer + `TRS_WORD;
            memReq <= 1'b0;
            memWe <= 1'b0;
            if (opndSel) begin
              pcValue <= handler;
              execSpace <= 1'b1;
              pcLoad <= 1'b1;
              cmdDone <= 1'b1;
              state <= ST_IDLE;
            end else begin
              opndSel <= 1'b1;
              state <= ST_OPND_RD;
            end
          end
        end
        ST_CO_RD0: begin
          if (memAck) begin
            firstResult <= memRdata;
            memWe <= 1'b1;
            memWdata <= opA;
            state <= ST_CO_WR0;
          end
        end
        ST_CO_WR0: begin
          if (memAck) begin
            firstResultValid <= 1'b1;
            memWe <= 1'b0;
            memAddr <= opB + `TRS_WORD;
            state <= ST_CO_RD1;
          end
        end
        ST_CO_RD1: begin
          if (memAck) begin
            retAddr <= memRdata;
            memWe <= 1'b1;
            memWdata <= followingInstrAddr;
            state <= ST_CO_WR1;
          end
        end
        ST_CO_WR1: begin
          if (memAck) begin
            memReq <= 1'b0;
            memWe <= 1'b0;
            pcValue <= retAddr;
            pcLoad <= 1'b1;
            cmdDone <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          memReq <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // trs_sequencer

// file: trs_regs.vh
// Constants shared by the trap and return sequencer: register map, layouts and encodings.
`ifndef TRS_REGS_VH
`define TRS_REGS_VH
// ====================================================================
// Register offsets on the AXI4-Lite bus (byte addresses).
`define TRS_OFF_CTRL 8'h00
`define TRS_OFF_VECBASE 8'h04
`define TRS_OFF_IRQ_STATUS 8'h08
`define TRS_OFF_IRQ_MASK 8'h0C
`define TRS_OFF_PC 8'h10
`define TRS_OFF_SP 8'h14
`define TRS_OFF_STATE 8'h18
`define TRS_RESP_OKAY 2'h0
`define TRS_RESP_SLVERR 2'h2
// ====================================================================
// Reset values.
`define TRS_CTRL_RESET 1'h1
`define TRS_VECBASE_RESET 32'h0000_1000
`define TRS_SP_RESET 32'h0000_2000
`define TRS_PC_RESET 32'h0000_0000
`define TRS_ZERO32 32'h0000_0000
// ====================================================================
// Operation codes on the command port.
`define TRS_OP_USER_RET 3'h0
`define TRS_OP_FULL_RET 3'h1
`define TRS_OP_EXEC_TRAP 3'h2
`define TRS_OP_CORO 3'h3
`define TRS_OP_PLAIN_JUMP 3'h4
`define TRS_OP_CALL_JUMP 3'h5
`define TRS_OP_RET_JUMP 3'h6
// ====================================================================
// Stack word size, save area layout and trap vector layout.
`define TRS_WORD 32'h0000_0004
`define TRS_VEC_SHIFT 3
`define TRS_SAVE_PC 3'h0
`define TRS_SAVE_NEXT 3'h1
`define TRS_SAVE_USR 3'h2
`define TRS_SAVE_PSW 3'h3
`define TRS_SAVE_STATE 3'h4
`define TRS_SAVE_LAST 3'h4
// Segment number occupies this bit of an address and those above it.
`define TRS_SEG_LSB 20
// Processor status bit positions.
`define TRS_PSW_TRACE_EN 0
`define TRS_PSW_CALL_PEND 1
// Operand descriptor fields and evaluation modes.
`define TRS_MODE1_LSB 0
`define TRS_MODE2_LSB 2
`define TRS_MODE_NONE 2'h0
`define TRS_MODE_ADDR 2'h1
// ====================================================================
// Interrupt status bits.
`define TRS_IRQ_SEG 0
`define TRS_IRQ_ILLEGAL 1
`define TRS_IRQ_TRAP 2
`define TRS_IRQ_CALL 3
`define TRS_IRQ_RET 4
`define TRS_IRQ_W 5
`endif

// file: trs_irq_bank.v
// Sticky event flags with write-one-to-clear, a mask and one level interrupt.
`timescale 1ns/1ps
module trs_irq_bank #(
  parameter W = 5
) (
  input wire clock,
  input wire rst,
  input wire [W-1:0] events,
  input wire clearWrite,
  input wire [W-1:0] clearBits,
  input wire maskWrite,
  input wire [W-1:0] maskBits,
  output reg [W-1:0] status,
  output reg [W-1:0] mask,
  output wire irq
);
  // ==================================================================
  // Flag storage.
  // A new event beats a clear in the same cycle so no event is lost.
  always @(posedge clock) begin
    if (rst) begin
      status <= {W{1'b0}};
    end else if (clearWrite) begin
      status <= (status & ~clearBits) | events;
    end else begin
      status <= status | events;
    end
  end

  // Mask register, one enable bit per flag.
  always @(posedge clock) begin
    if (rst) begin
      mask <= {W{1'b0}};
    end else if (maskWrite) begin
      mask <= maskBits;
    end
  end

  // Level output while any unmasked flag is set.
  assign irq = |(status & mask);
endmodule // trs_irq_bank

// file: trs_sequencer_asserts.sv
// Concurrent checks on the sequencer's command, memory and fault ports.
`timescale 1ns/1ps
`include "trs_regs.vh"
module trs_seq_asserts (
  input wire clock,
  input wire rst,
  input wire cmdValid,
  input wire cmdReady,
  input wire [2:0] cmdOp,
  input wire [31:0] firstOperand,
  input wire [31:0] secondOperand,
  input wire userMode,
  input wire callTraceEnable,
  input wire memReq,
  input wire memAck,
  input wire [31:0] memAddr,
  input wire cmdDone,
  input wire pcLoad,
  input wire [31:0] pcValue,
  input wire [31:0] stackTopPointer,
  input wire segmentCrossFault,
  input wire illegalOpFault,
  input wire callEvent,
  input wire returnEvent
);
  // ==========================================================
  // A command is taken on the edge where valid meets ready.
  wire take = cmdValid && cmdReady;
  wire sameSeg = secondOperand[31:`TRS_SEG_LSB] == stackTopPointer[31:`TRS_SEG_LSB];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // The pointer is popped on the acceptance edge and checked on the next one.
  illegal_full_a: assert property (take && cmdOp == `TRS_OP_FULL_RET && userMode |=> illegalOpFault && cmdDone) else $error("full return in user mode not refused");
  seg_cross_a: assert property (take && cmdOp == `TRS_OP_USER_RET && !sameSeg |=> segmentCrossFault && cmdDone) else $error("segment crossing not faulted");
  fault_still_a: assert property (segmentCrossFault || illegalOpFault |-> !pcLoad && stackTopPointer == $past(stackTopPointer)) else $error("faulting return changed state");
  full_sp_a: assert property (take && cmdOp == `TRS_OP_FULL_RET && !userMode && sameSeg |=> stackTopPointer == $past(secondOperand)) else $error("full return pointer wrong");
  jump_pc_a: assert property (take && cmdOp == `TRS_OP_PLAIN_JUMP |=> pcLoad && pcValue == $past(firstOperand)) else $error("plain jump target wrong");
  call_mark_a: assert property (take && cmdOp == `TRS_OP_CALL_JUMP |=> callEvent == $past(callTraceEnable)) else $error("call mark wrong");
  ret_mark_a: assert property (take && cmdOp == `TRS_OP_RET_JUMP |=> returnEvent == $past(callTraceEnable)) else $error("return mark wrong");
  mem_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr)) else $error("memory request dropped early");
  busy_refuse_a: assert property (memReq |-> !cmdReady) else $error("command taken while busy");
  cover property (take && cmdOp == `TRS_OP_EXEC_TRAP);
  cover property (segmentCrossFault);
  cover property (cmdDone && pcLoad);
endmodule // trs_seq_asserts
bind trs_sequencer trs_seq_asserts trs_seq_asserts_i (.clock, .rst, .cmdValid, .cmdReady,
  .cmdOp, .firstOperand, .secondOperand, .userMode, .callTraceEnable, .memReq, .memAck,
  .memAddr, .cmdDone, .pcLoad, .pcValue, .stackTopPointer, .segmentCrossFault,
  .illegalOpFault, .callEvent, .returnEvent);

// file: testbench.sv
// Self-checking bench for the trap and return sequencer.
`timescale 1ns/1ps
`include "trs_regs.vh"
module testbench;
  logic clock = 0;
  logic rst = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic cmdValid = 0, userMode = 0, callTraceEnable = 0, memAck = 0;
  logic [2:0] cmdOp = 0;
  logic [5:0] cmdModifier = 0;
  logic [31:0] firstOperand = 0, secondOperand = 0, firstValue = 0;
  logic [31:0] followingInstrAddr = 0, memRdata = 0;
  wire cmdReady, memReq, memWe, cmdDone, pcLoad, singleStepPending, callWatchPending;
  wire execSpace, firstResultValid, segmentCrossFault, illegalOpFault;
  wire callEvent, returnEvent, irq;
  wire [31:0] memAddr, memWdata, pcValue, stackTopPointer;
  wire [31:0] userStatus, procStatus, elementState, firstResult;
  int bad_count = 0;
  int n_tests = 0;
  logic [4:0] ev;
  logic [31:0] d;
  logic [1:0] r;
  logic [31:0] mem [logic [31:0]];
  // Rows: opcode, trace enable, expected call mark, expected return mark.
  logic [5:0] rows [6] = '{6'h20, 6'h28, 6'h30, 6'h24, 6'h2E, 6'h35};
  trs_sequencer trs_sequencer_i (.*);
  always #2.5 clock = ~clock;
  // ==========================================================
  // Memory answers each request one cycle later with a single ack.
  always @(posedge clock) begin
    memAck <= memReq && !memAck;
    if (memReq && !memAck && memWe) mem[memAddr] = memWdata;
    if (memReq && !memAck) memRdata <= mem.exists(memAddr) ? mem[memAddr] : 32'hFFFF_FFFF;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge clock);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge clock);
  endtask
  // Offers one command and gathers the pulses seen until it completes.
  task automatic cmd(input logic [2:0] o, input logic [5:0] m, input logic [31:0] a, b);
    int n;
    cmdOp <= o;
    cmdModifier <= m;
    firstOperand <= a;
    secondOperand <= b;
    cmdValid <= 1;
    do @(posedge clock); while (!cmdReady);
    cmdValid <= 0;
    ev = 0;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      ev = ev | {firstResultValid, callEvent, returnEvent, segmentCrossFault, illegalOpFault};
      if (cmdDone === 1'b1) break;
    end
    if (n == 100) chk("cmdDone", 0, 1);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    print_verdict;
  end
  initial begin
    logic [31:0] sa [5] = '{32'h400, 32'h404, 32'h55, 32'h3, 32'h2};
    foreach (sa[i]) mem[32'h2100 + 4 * i] = sa[i];
    foreach (sa[i]) mem[32'h2200 + 4 * i] = i < 2 ? 32'h500 + 4 * i : (i == 2 ? 32'h66 : 0);
    mem[32'h11F8] = 32'h800;
    mem[32'h11FC] = 32'h9;
    mem[32'h3100] = 32'h77;
    mem[32'h2300] = 32'hAAAA;
    mem[32'h2304] = 32'h900;
    repeat (6) @(posedge clock);
    rst <= 0;
    axr(`TRS_OFF_CTRL);
    chk("ctrl", d, 1);
    axr(`TRS_OFF_VECBASE);
    chk("vecbase", d, `TRS_VECBASE_RESET);
    chk("sp", stackTopPointer, `TRS_SP_RESET);
    axr(8'h1C);
    chk("unmapped", {30'h0000_0000, r}, `TRS_RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      callTraceEnable <= rows[i][2];
      cmd(rows[i][5:3], 0, 32'h700 + i, 0);
      chk("pc", pcValue, 32'h700 + i);
      chk("marks", {30'h0000_0000, ev[3:2]}, {30'h0000_0000, rows[i][1:0]});
    end
    $display("test jumps done");
    cmd(`TRS_OP_USER_RET, 0, 32'h2100, 32'h0010_0000);
    chk("segfault", ev[1], 1);
    chk("sp", stackTopPointer, `TRS_SP_RESET);
    userMode <= 1;
    cmd(`TRS_OP_FULL_RET, 1, 32'h2100, 32'h20F0);
    chk("illegal", ev[0], 1);
    chk("sp", stackTopPointer, `TRS_SP_RESET);
    userMode <= 0;
    $display("test faults done");
    cmd(`TRS_OP_FULL_RET, 1, 32'h2100, 32'h20F0);
    chk("sp", stackTopPointer, 32'h20F0);
    chk("pc", pcValue, 32'h400);
    chk("user", userStatus, 32'h55);
    chk("proc", procStatus, 32'h3);
    chk("element", elementState, 32'h3);
    chk("pending", {singleStepPending, callWatchPending}, 2'b11);
    for (int m = 0; m < 2; m++) begin
      cmd(`TRS_OP_USER_RET, m, 32'h2200, 32'h20F0);
      chk("pc", pcValue, 32'h500 + 4 * m);
      chk("user", userStatus, 32'h66);
      chk("proc", procStatus, 32'h3);
    end
    $display("test returns done");
    cmd(`TRS_OP_EXEC_TRAP, 63, 32'h3000, 32'h3100);
    chk("pc", pcValue, 32'h800);
    chk("space", execSpace, 1);
    chk("pushed", mem[32'h20F0], 32'h3000);
    chk("pushed2", mem[32'h20F4], 32'h77);
    chk("sp", stackTopPointer, 32'h20F8);
    axr(`TRS_OFF_IRQ_STATUS);
    chk("status", d, 32'h1F);
    chk("irq", irq, 0);
    axw(`TRS_OFF_IRQ_MASK, 32'h4);
    chk("irq", irq, 1);
    axw(`TRS_OFF_IRQ_STATUS, 32'h1F);
    chk("irq", irq, 0);
    $display("test trap done");
    followingInstrAddr <= 32'h604;
    cmd(`TRS_OP_CORO, 0, 32'h3000, 32'h2300);
    chk("swapped", firstResult, 32'hAAAA);
    chk("swapvalid", ev[4], 1);
    chk("slot", mem[32'h2300], 32'h3000);
    chk("link", mem[32'h2304], 32'h604);
    chk("pc", pcValue, 32'h900);
    $display("test coroutine done");
    print_verdict;
  end
endmodule // testbench
